// [include/p2pfs_pkg.sv]
// Constants and helpers for the port 2 low-pin function select block
package p2pfs_pkg;

    localparam int P2PFS_NUM_PINS = 5;
    localparam int P2PFS_ADDR_W = 18;

    // Register indices; byte address is four times the index
    localparam logic [15:0] P2PFS_PIN0_CFG_IDX = 16'ha070;
    localparam logic [15:0] P2PFS_PIN1_CFG_IDX = 16'ha071;
    localparam logic [15:0] P2PFS_PIN2_CFG_IDX = 16'ha072;
    localparam logic [15:0] P2PFS_PIN3_CFG_IDX = 16'ha073;
    localparam logic [15:0] P2PFS_PIN4_CFG_IDX = 16'ha074;
    localparam logic [15:0] P2PFS_PIN_LEVEL_IDX = 16'ha080;
    localparam logic [15:0] P2PFS_CONFLICT_IDX = 16'ha081;

    localparam logic [7:0] P2PFS_CFG_RESET = 8'h00;

    // Field positions shared by all pin registers
    localparam int P2PFS_BIT_PLAIN_IO = 0;
    localparam int P2PFS_BIT_IRQ_A = 1;
    localparam int P2PFS_BIT_IRQ_B = 2;
    localparam int P2PFS_BIT_FN3 = 3;
    localparam int P2PFS_BIT_FN4 = 4;
    localparam int P2PFS_BIT_FN5 = 5;
    localparam int P2PFS_BIT_FN6 = 6;
    localparam int P2PFS_BIT_ANALOG = 7;

    // Implemented bits per pin
    localparam logic [7:0] P2PFS_PIN0_MASK = 8'hff;
    localparam logic [7:0] P2PFS_PIN1_MASK = 8'hff;
    localparam logic [7:0] P2PFS_PIN2_MASK = 8'hbf;
    localparam logic [7:0] P2PFS_PIN3_MASK = 8'hbf;
    localparam logic [7:0] P2PFS_PIN4_MASK = 8'hb7;

    // Bits that select a function able to drive the pad, per pin
    localparam logic [7:0] P2PFS_PIN0_DRV = 8'h79;
    localparam logic [7:0] P2PFS_PIN1_DRV = 8'h79;
    localparam logic [7:0] P2PFS_PIN2_DRV = 8'h19;
    localparam logic [7:0] P2PFS_PIN3_DRV = 8'h01;
    localparam logic [7:0] P2PFS_PIN4_DRV = 8'h21;

    // Implemented-bit mask of a pin
    function automatic logic [7:0] p2pfs_mask(input logic [2:0] pin);
        logic [7:0] m;
        m = 8'h00;
        unique case (pin)
            3'h0: m = P2PFS_PIN0_MASK;
            3'h1: m = P2PFS_PIN1_MASK;
            3'h2: m = P2PFS_PIN2_MASK;
            3'h3: m = P2PFS_PIN3_MASK;
            3'h4: m = P2PFS_PIN4_MASK;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // Word address hit on a register index
    function automatic logic p2pfs_hit(input logic [P2PFS_ADDR_W-1:0] addr,
                                       input logic [15:0] idx);
        return addr[P2PFS_ADDR_W-1:2] == idx;
    endfunction

    // More than one bit set
    function automatic logic p2pfs_multi(input logic [7:0] v);
        return (v & (v - 8'h01)) != 8'h00;
    endfunction

endpackage

// [verilog/p2pfs_cfg_regs.sv]
// Per-pin function configuration storage for the port 2 pin select block
`timescale 1ns/1ps
`default_nettype none
module p2pfs_cfg_regs
    import p2pfs_pkg::*;
#(
    parameter int NUM_PINS = P2PFS_NUM_PINS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_pin_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [2:0] rd_pin_i,
    output logic [7:0] rd_data_o,
    output logic [NUM_PINS*8-1:0] cfg_o
);

    logic [7:0] cfg_ff [NUM_PINS];
    logic [7:0] nxt_cfg [NUM_PINS];

    // Next value: only implemented bits take the write
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            nxt_cfg[i] = cfg_ff[i];
            if (wr_en_i && (wr_pin_i == i[2:0])) begin
                nxt_cfg[i] = wr_data_i & p2pfs_mask(i[2:0]);
            end
        end
    end

    // Storage, cleared on reset
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (sys_rst_i) begin
                cfg_ff[i] <= P2PFS_CFG_RESET;
            end else begin
                cfg_ff[i] <= nxt_cfg[i];
            end
        end
    end

    // Read back with the write layout
    assign rd_data_o = (rd_pin_i < NUM_PINS) ? cfg_ff[rd_pin_i] : 8'h00;

    // Flattened view for the pin logic
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            cfg_o[i*8 +: 8] = cfg_ff[i];
        end
    end

endmodule // p2pfs_cfg_regs
`default_nettype wire

// [verilog/p2pfs_top.sv]
// Port 2 pins 0..4 function select with Avalon-MM register slave
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module p2pfs_top
    import p2pfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave, byte addressed
    input wire logic [P2PFS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Pads
    input wire logic [4:0] pad_in_i,
    output logic [4:0] pad_out_o,
    output logic [4:0] pad_oe_n_o,
    output logic [4:0] analog_path_sel_o,
    // Plain I/O controller
    input wire logic [4:0] plain_io_out_i,
    input wire logic [4:0] plain_io_oe_i,
    output logic [4:0] plain_io_in_o,
    // Shared pin interrupt conditions
    output logic shared_pin_irq_a_o,
    output logic shared_pin_irq_b_o,
    // I2C master controller
    input wire logic i2c_master_clock_out_i,
    input wire logic i2c_master_clock_oe_i,
    output logic i2c_master_clock_in_o,
    input wire logic i2c_master_data_out_i,
    input wire logic i2c_master_data_oe_i,
    output logic i2c_master_data_in_o,
    // I2C slave controller one
    input wire logic i2c_slave_one_clock_out_i,
    input wire logic i2c_slave_one_clock_oe_i,
    output logic i2c_slave_one_clock_in_o,
    input wire logic i2c_slave_one_data_out_i,
    input wire logic i2c_slave_one_data_oe_i,
    output logic i2c_slave_one_data_in_o,
    // Capture/compare channels four and five
    input wire logic capture_ch_four_out_i,
    input wire logic capture_ch_four_oe_i,
    output logic capture_ch_four_in_o,
    input wire logic capture_ch_five_out_i,
    input wire logic capture_ch_five_oe_i,
    output logic capture_ch_five_in_o,
    // SPI lines
    input wire logic spi_out_line_out_i,
    input wire logic spi_out_line_oe_i,
    output logic spi_out_line_in_o,
    input wire logic spi_in_line_out_i,
    input wire logic spi_in_line_oe_i,
    output logic spi_in_line_in_o,
    input wire logic spi_clock_line_out_i,
    input wire logic spi_clock_line_oe_i,
    output logic spi_clock_line_in_o,
    output logic spi_select_line_in_o,
    // Second serial port, motor PWM, timer two
    input wire logic serial_two_transmit_i,
    output logic serial_two_receive_o,
    output logic pwm_emergency_o,
    input wire logic motor_pwm_c_positive_i,
    output logic timer_two_input_o
);

    // ------------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------------
    logic [39:0] cfg;
    logic [7:0] cfg_rd_data;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;

    // Address decode
    wire bus_req = avs_read_i | avs_write_i;
    wire hit_pin0 = p2pfs_hit(avs_address_i, P2PFS_PIN0_CFG_IDX);
    wire hit_pin1 = p2pfs_hit(avs_address_i, P2PFS_PIN1_CFG_IDX);
    wire hit_pin2 = p2pfs_hit(avs_address_i, P2PFS_PIN2_CFG_IDX);
    wire hit_pin3 = p2pfs_hit(avs_address_i, P2PFS_PIN3_CFG_IDX);
    wire hit_pin4 = p2pfs_hit(avs_address_i, P2PFS_PIN4_CFG_IDX);
    wire hit_level = p2pfs_hit(avs_address_i, P2PFS_PIN_LEVEL_IDX);
    wire hit_conflict = p2pfs_hit(avs_address_i, P2PFS_CONFLICT_IDX);
    wire hit_cfg = hit_pin0 | hit_pin1 | hit_pin2 | hit_pin3 | hit_pin4;
    wire [2:0] pin_sel = hit_pin1 ? 3'h1 :
                         hit_pin2 ? 3'h2 :
                         hit_pin3 ? 3'h3 :
                         hit_pin4 ? 3'h4 : 3'h0;

    // Write only in the cycle the request is accepted, low lane only
    wire cfg_wr = avs_write_i & ack_ff & hit_cfg & avs_byteenable_i[0];

    p2pfs_cfg_regs #(
        .NUM_PINS(P2PFS_NUM_PINS)
    ) u_regs (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(cfg_wr),
        .wr_pin_i(pin_sel),
        .wr_data_i(avs_writedata_i[7:0]),
        .rd_pin_i(pin_sel),
        .rd_data_o(cfg_rd_data),
        .cfg_o(cfg)
    );

    // Per-pin register views
    wire [7:0] cfg0 = cfg[7:0];
    wire [7:0] cfg1 = cfg[15:8];
    wire [7:0] cfg2 = cfg[23:16];
    wire [7:0] cfg3 = cfg[31:24];
    wire [7:0] cfg4 = cfg[39:32];

    // Pins with more than one driving function requested
    wire [4:0] conflict;
    assign conflict[0] = p2pfs_multi(cfg0 & P2PFS_PIN0_DRV);
    assign conflict[1] = p2pfs_multi(cfg1 & P2PFS_PIN1_DRV);
    assign conflict[2] = p2pfs_multi(cfg2 & P2PFS_PIN2_DRV);
    assign conflict[3] = p2pfs_multi(cfg3 & P2PFS_PIN3_DRV);
    assign conflict[4] = p2pfs_multi(cfg4 & P2PFS_PIN4_DRV);

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hit_cfg) begin
            nxt_rdata = {24'h00_0000, cfg_rd_data};
        end else if (hit_level) begin
            nxt_rdata = {27'h000_0000, sync2_ff};
        end else if (hit_conflict) begin
            nxt_rdata = {27'h000_0000, conflict};
        end
    end

    // One wait state per access keeps the read data registered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (avs_read_i && !ack_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign avs_waitrequest_o = bus_req & ~ack_ff;
    assign avs_readdata_o = rdata_ff;

    // ------------------------------------------------------------------
    // Pad input synchroniser; stage one is read by stage two only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
        end else begin
            sync1_ff <= pad_in_i;
            sync2_ff <= sync1_ff;
        end
    end

    wire [4:0] lvl = sync2_ff;

    // ------------------------------------------------------------------
    // Pad drivers, highest selected bit owns the pad
    // ------------------------------------------------------------------
    logic [4:0] pad_out_ff;
    logic [4:0] pad_oe_n_ff;
    logic [4:0] nxt_pad_out;
    logic [4:0] nxt_pad_oe_n;

    // Pin 0: analog, I2C master clock, slave one clock, capture four, SPI out, plain I/O
    wire p0_an = cfg0[P2PFS_BIT_ANALOG];
    wire p0_mscl = cfg0[P2PFS_BIT_FN6];
    wire p0_sscl = cfg0[P2PFS_BIT_FN5];
    wire p0_cap = cfg0[P2PFS_BIT_FN4];
    wire p0_mosi = cfg0[P2PFS_BIT_FN3];
    wire p0_io = cfg0[P2PFS_BIT_PLAIN_IO];
    assign nxt_pad_out[0] = p0_mscl ? i2c_master_clock_out_i :
                            p0_sscl ? i2c_slave_one_clock_out_i :
                            p0_cap ? capture_ch_four_out_i :
                            p0_mosi ? spi_out_line_out_i :
                            p0_io ? plain_io_out_i[0] : 1'b0;
    wire p0_oe = p0_an ? 1'b0 :
                 p0_mscl ? i2c_master_clock_oe_i :
                 p0_sscl ? i2c_slave_one_clock_oe_i :
                 p0_cap ? capture_ch_four_oe_i :
                 p0_mosi ? spi_out_line_oe_i :
                 p0_io ? plain_io_oe_i[0] : 1'b0;
    assign nxt_pad_oe_n[0] = ~p0_oe;

    // Pin 1: crystal out, I2C master data, slave one data, capture five, SPI in
    wire p1_an = cfg1[P2PFS_BIT_ANALOG];
    wire p1_msda = cfg1[P2PFS_BIT_FN6];
    wire p1_ssda = cfg1[P2PFS_BIT_FN5];
    wire p1_cap = cfg1[P2PFS_BIT_FN4];
    wire p1_miso = cfg1[P2PFS_BIT_FN3];
    wire p1_io = cfg1[P2PFS_BIT_PLAIN_IO];
    assign nxt_pad_out[1] = p1_msda ? i2c_master_data_out_i :
                            p1_ssda ? i2c_slave_one_data_out_i :
                            p1_cap ? capture_ch_five_out_i :
                            p1_miso ? spi_in_line_out_i :
                            p1_io ? plain_io_out_i[1] : 1'b0;
    wire p1_oe = p1_an ? 1'b0 :
                 p1_msda ? i2c_master_data_oe_i :
                 p1_ssda ? i2c_slave_one_data_oe_i :
                 p1_cap ? capture_ch_five_oe_i :
                 p1_miso ? spi_in_line_oe_i :
                 p1_io ? plain_io_oe_i[1] : 1'b0;
    assign nxt_pad_oe_n[1] = ~p1_oe;

    // Pin 2: DAC out, emergency in, serial two transmit, SPI clock
    wire p2_an = cfg2[P2PFS_BIT_ANALOG];
    wire p2_emg = cfg2[P2PFS_BIT_FN5];
    wire p2_txd = cfg2[P2PFS_BIT_FN4];
    wire p2_sck = cfg2[P2PFS_BIT_FN3];
    wire p2_io = cfg2[P2PFS_BIT_PLAIN_IO];
    assign nxt_pad_out[2] = p2_txd ? serial_two_transmit_i :
                            p2_sck ? spi_clock_line_out_i :
                            p2_io ? plain_io_out_i[2] : 1'b0;
    // An input function above the drivers also keeps the pad released
    wire p2_oe = (p2_an | p2_emg) ? 1'b0 :
                 p2_txd ? 1'b1 :
                 p2_sck ? spi_clock_line_oe_i :
                 p2_io ? plain_io_oe_i[2] : 1'b0;
    assign nxt_pad_oe_n[2] = ~p2_oe;

    // Pin 3: threshold in, emergency in, serial two receive, SPI select
    wire p3_an = cfg3[P2PFS_BIT_ANALOG];
    wire p3_emg = cfg3[P2PFS_BIT_FN5];
    wire p3_rxd = cfg3[P2PFS_BIT_FN4];
    wire p3_ssn = cfg3[P2PFS_BIT_FN3];
    wire p3_io = cfg3[P2PFS_BIT_PLAIN_IO];
    wire p3_in_only = p3_an | p3_emg | p3_rxd | p3_ssn;
    assign nxt_pad_out[3] = p3_io ? plain_io_out_i[3] : 1'b0;
    wire p3_oe = p3_in_only ? 1'b0 : (p3_io & plain_io_oe_i[3]);
    assign nxt_pad_oe_n[3] = ~p3_oe;

    // Pin 4: comparator D in, motor PWM C positive out, timer two in
    wire p4_an = cfg4[P2PFS_BIT_ANALOG];
    wire p4_pwm = cfg4[P2PFS_BIT_FN5];
    wire p4_tmr = cfg4[P2PFS_BIT_FN4];
    wire p4_io = cfg4[P2PFS_BIT_PLAIN_IO];
    assign nxt_pad_out[4] = p4_pwm ? motor_pwm_c_positive_i :
                            p4_io ? plain_io_out_i[4] : 1'b0;
    wire p4_oe = p4_an ? 1'b0 :
                 p4_pwm ? 1'b1 :
                 p4_tmr ? 1'b0 :
                 p4_io ? plain_io_oe_i[4] : 1'b0;
    assign nxt_pad_oe_n[4] = ~p4_oe;

    // Registered pad drive; released during reset so no pad fights the board
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pad_out_ff <= 5'h00;
            pad_oe_n_ff <= 5'h1f;
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_n_ff <= nxt_pad_oe_n;
        end
    end

    assign pad_out_o = pad_out_ff;
    assign pad_oe_n_o = pad_oe_n_ff;

    // Analog switch selects come straight from the register bits
    assign analog_path_sel_o = {p4_an, p3_an, p2_an, p1_an, p0_an};

    // ------------------------------------------------------------------
    // Input routing to peripherals and interrupt conditions
    // ------------------------------------------------------------------
    logic [4:0] io_in_ff;
    logic irq_a_ff;
    logic irq_b_ff;
    logic [15:0] route_ff;
    logic [15:0] nxt_route;

    wire [4:0] irq_a_en;
    wire [4:0] irq_b_en;
    wire [4:0] io_en;
    assign irq_a_en = {cfg4[P2PFS_BIT_IRQ_A], cfg3[P2PFS_BIT_IRQ_A], cfg2[P2PFS_BIT_IRQ_A],
                       cfg1[P2PFS_BIT_IRQ_A], cfg0[P2PFS_BIT_IRQ_A]};
    assign irq_b_en = {cfg4[P2PFS_BIT_IRQ_B], cfg3[P2PFS_BIT_IRQ_B], cfg2[P2PFS_BIT_IRQ_B],
                       cfg1[P2PFS_BIT_IRQ_B], cfg0[P2PFS_BIT_IRQ_B]};
    assign io_en = {p4_io, p3_io, p2_io, p1_io, p0_io};

    // Conditions are OR-combined; A and B are decoded independently per pin
    wire nxt_irq_a = |(lvl & irq_a_en);
    wire nxt_irq_b = |(lvl & irq_b_en);

    // Idle levels: I2C, SPI select and serial two receive idle high, the rest low
    assign nxt_route[0] = p0_mscl ? lvl[0] : 1'b1;
    assign nxt_route[1] = p1_msda ? lvl[1] : 1'b1;
    assign nxt_route[2] = p0_sscl ? lvl[0] : 1'b1;
    assign nxt_route[3] = p1_ssda ? lvl[1] : 1'b1;
    assign nxt_route[4] = p0_cap ? lvl[0] : 1'b0;
    assign nxt_route[5] = p1_cap ? lvl[1] : 1'b0;
    assign nxt_route[6] = p0_mosi ? lvl[0] : 1'b0;
    assign nxt_route[7] = p1_miso ? lvl[1] : 1'b0;
    assign nxt_route[8] = p2_sck ? lvl[2] : 1'b0;
    assign nxt_route[9] = p3_ssn ? lvl[3] : 1'b1;
    assign nxt_route[10] = p3_rxd ? lvl[3] : 1'b1;
    // Either emergency pin may trip the PWM unit
    assign nxt_route[11] = (p2_emg & lvl[2]) | (p3_emg & lvl[3]);
    assign nxt_route[12] = p4_tmr ? lvl[4] : 1'b0;
    assign nxt_route[15:13] = 3'h0;

    // Peripheral-side inputs are registered to keep outputs glitch free
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            io_in_ff <= 5'h00;
            irq_a_ff <= 1'b0;
            irq_b_ff <= 1'b0;
            route_ff <= 16'h060f;
        end else begin
            io_in_ff <= lvl & io_en;
            irq_a_ff <= nxt_irq_a;
            irq_b_ff <= nxt_irq_b;
            route_ff <= nxt_route;
        end
    end

    assign plain_io_in_o = io_in_ff;
    assign shared_pin_irq_a_o = irq_a_ff;
    assign shared_pin_irq_b_o = irq_b_ff;
    assign i2c_master_clock_in_o = route_ff[0];
    assign i2c_master_data_in_o = route_ff[1];
    assign i2c_slave_one_clock_in_o = route_ff[2];
    assign i2c_slave_one_data_in_o = route_ff[3];
    assign capture_ch_four_in_o = route_ff[4];
    assign capture_ch_five_in_o = route_ff[5];
    assign spi_out_line_in_o = route_ff[6];
    assign spi_in_line_in_o = route_ff[7];
    assign spi_clock_line_in_o = route_ff[8];
    assign spi_select_line_in_o = route_ff[9];
    assign serial_two_receive_o = route_ff[10];
    assign pwm_emergency_o = route_ff[11];
    assign timer_two_input_o = route_ff[12];

endmodule // p2pfs_top
`default_nettype wire

// [sim/p2pfs_pad_model.sv]
// Pad wires and far-side levels for the port 2 function select block
`timescale 1ns/1ps
`default_nettype none
module p2pfs_pad_model (
    input wire logic [4:0] lvl_i,
    input wire logic [4:0] pad_out_i,
    input wire logic [4:0] pad_oe_n_i,
    output logic [4:0] pad_o
);
    // Driven pads read back the block's own value, released ones the outside level
    assign pad_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & lvl_i);
endmodule // p2pfs_pad_model
`default_nettype wire

// [sim/p2pfs_asserts.sv]
// Bus timing and pad relation checks for the port 2 function select block
`timescale 1ns/1ps
`default_nettype none
module p2pfs_asserts
    import p2pfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [4:0] pad_in_i,
    input wire logic [4:0] pad_out_o,
    input wire logic [4:0] pad_oe_n_o,
    input wire logic [4:0] analog_path_sel_o,
    input wire logic [4:0] plain_io_in_o,
    input wire logic shared_pin_irq_a_o,
    input wire logic shared_pin_irq_b_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [19:0] hist_ff;
    logic [4:0] seen;
    // Recent pad levels; the exact sync depth stays hidden, so any of four counts
    always_ff @(posedge clk_i) begin
        hist_ff <= {hist_ff[14:0], pad_in_i};
    end
    assign seen = hist_ff[4:0] | hist_ff[9:5] | hist_ff[14:10] | hist_ff[19:15];
    // Bus answer and register read shape
    a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer after one wait");
    a_idle_no_wait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o) else $error("wait without request");
    a_read_byte: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0) else $error("read beyond byte");
    a_data_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("read data moved");
    a_reset_pads: assert property ($fell(sys_rst_i) |-> pad_oe_n_o == 5'h1f && pad_out_o == 5'h00 && !shared_pin_irq_a_o && !shared_pin_irq_b_o) else $error("pads not idle after reset");
    // Inputs only follow levels the pads really had; analog-selected pads stay undriven
    a_irq_a_src: assert property (shared_pin_irq_a_o |-> seen != 5'h00) else $error("irq a without pad");
    a_irq_b_src: assert property (shared_pin_irq_b_o |-> seen != 5'h00) else $error("irq b without pad");
    a_plain_src: assert property ((plain_io_in_o & ~seen) == 5'h00) else $error("plain in without pad");
    a_analog_off: assert property (((analog_path_sel_o & $past(analog_path_sel_o)) & ~pad_oe_n_o) == 5'h00) else $error("analog pad driven");
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
    c_both_irq: cover property (shared_pin_irq_a_o && shared_pin_irq_b_o);
endmodule // p2pfs_asserts
bind p2pfs_top p2pfs_asserts u_chk (.clk_i, .sys_rst_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .pad_in_i, .pad_out_o, .pad_oe_n_o,
    .analog_path_sel_o, .plain_io_in_o, .shared_pin_irq_a_o, .shared_pin_irq_b_o);
`default_nettype wire

// [sim/tb_top.sv]
// Register and pad scenarios for the port 2 function select block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import p2pfs_pkg::*;
;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [P2PFS_ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [4:0] lvl = 5'h00;
    logic [4:0] plain_io_out_i = 5'h00;
    logic [4:0] plain_io_oe_i = 5'h00;
    logic poe = 1'b0;
    logic pon = 1'b0;
    logic mclk = 1'b0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [4:0] pad_in_i, pad_out_o, pad_oe_n_o, analog_path_sel_o, plain_io_in_o;
    logic shared_pin_irq_a_o, shared_pin_irq_b_o, serial_two_receive_o, timer_two_input_o;
    int n_errors = 0;
    int n_tests = 0;
    logic [7:0] msk [5] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'hb7};
    logic [6:0] it [5] = '{7'h06, 7'h0b, 7'h11, 7'h60, 7'h0f};
    // Pin, setting, released, pad value; analog and I2C rows assume software duties
    logic [12:0] ft [22] = '{
        {3'd0, 8'h80, 2'b10}, {3'd0, 8'h40, 2'b00}, {3'd0, 8'h41, 2'b00},
        {3'd0, 8'h20, 2'b01}, {3'd0, 8'h10, 2'b01}, {3'd0, 8'h08, 2'b01},
        {3'd1, 8'h80, 2'b10}, {3'd1, 8'h40, 2'b01}, {3'd1, 8'h20, 2'b01},
        {3'd1, 8'h10, 2'b01}, {3'd1, 8'h08, 2'b01}, {3'd2, 8'h80, 2'b10},
        {3'd2, 8'h20, 2'b10}, {3'd2, 8'h10, 2'b01}, {3'd2, 8'h08, 2'b01},
        {3'd3, 8'h80, 2'b10}, {3'd3, 8'h20, 2'b10}, {3'd3, 8'h10, 2'b10},
        {3'd3, 8'h08, 2'b10}, {3'd4, 8'h80, 2'b10}, {3'd4, 8'h20, 2'b01},
        {3'd4, 8'h10, 2'b10}};
    p2pfs_top uut (
        .clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pad_in_i, .pad_out_o,
        .pad_oe_n_o, .analog_path_sel_o, .plain_io_out_i, .plain_io_oe_i, .plain_io_in_o,
        .shared_pin_irq_a_o, .shared_pin_irq_b_o, .serial_two_receive_o, .timer_two_input_o,
        .i2c_master_clock_out_i(mclk), .i2c_master_clock_oe_i(poe), .i2c_master_clock_in_o(),
        .i2c_master_data_out_i(pon), .i2c_master_data_oe_i(poe), .i2c_master_data_in_o(),
        .i2c_slave_one_clock_out_i(pon), .i2c_slave_one_clock_oe_i(poe),
        .i2c_slave_one_clock_in_o(), .i2c_slave_one_data_out_i(pon),
        .i2c_slave_one_data_oe_i(poe), .i2c_slave_one_data_in_o(),
        .capture_ch_four_out_i(pon), .capture_ch_four_oe_i(poe), .capture_ch_four_in_o(),
        .capture_ch_five_out_i(pon), .capture_ch_five_oe_i(poe), .capture_ch_five_in_o(),
        .spi_out_line_out_i(pon), .spi_out_line_oe_i(poe), .spi_out_line_in_o(),
        .spi_in_line_out_i(pon), .spi_in_line_oe_i(poe), .spi_in_line_in_o(),
        .spi_clock_line_out_i(pon), .spi_clock_line_oe_i(poe), .spi_clock_line_in_o(),
        .spi_select_line_in_o(), .serial_two_transmit_i(pon), .pwm_emergency_o(),
        .motor_pwm_c_positive_i(pon));
    p2pfs_pad_model u_pads (.lvl_i(lvl), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pad_o(pad_in_i));
    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One access; held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= 4'h1;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) n_errors++;
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (6000) @(posedge clk_i);
        n_errors++;
        report_and_stop();
    end
    initial begin
        logic [31:0] q;
        logic [2:0] p;
        logic [7:0] c;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk("pad oe reset", 32'(pad_oe_n_o), 32'h1f);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 16'(P2PFS_PIN0_CFG_IDX + i), 8'h00, q);
            chk("cfg reset", q, 32'h0);
            bus(1'b1, 16'(P2PFS_PIN0_CFG_IDX + i), 8'hff, q);
            bus(1'b0, 16'(P2PFS_PIN0_CFG_IDX + i), 8'h00, q);
            chk("cfg bits", q, 32'(msk[i]));
            bus(1'b1, 16'(P2PFS_PIN0_CFG_IDX + i), 8'h01, q);
        end
        bus(1'b0, 16'h0000, 8'h00, q);
        chk("unmapped", q, 32'h0);
        plain_io_out_i <= 5'h15;
        plain_io_oe_i <= 5'h1f;
        repeat (5) @(negedge clk_i);
        chk("plain oe", 32'(pad_oe_n_o), 32'h00);
        chk("plain out", 32'(pad_out_o), 32'h15);
        chk("plain in", 32'(plain_io_in_o), 32'h15);
        // Pin 1 feeds both interrupts; pins 3 and 4 feed none
        plain_io_oe_i <= 5'h00;
        bus(1'b1, P2PFS_PIN0_CFG_IDX, 8'h02, q);
        bus(1'b1, P2PFS_PIN1_CFG_IDX, 8'h06, q);
        bus(1'b1, P2PFS_PIN2_CFG_IDX, 8'h04, q);
        bus(1'b1, P2PFS_PIN3_CFG_IDX, 8'h00, q);
        bus(1'b1, P2PFS_PIN4_CFG_IDX, 8'h00, q);
        for (int i = 0; i < 5; i++) begin
            lvl <= it[i][6:2];
            repeat (6) @(negedge clk_i);
            chk("irq a", 32'(shared_pin_irq_a_o), 32'(it[i][1]));
            chk("irq b", 32'(shared_pin_irq_b_o), 32'(it[i][0]));
        end
        // Peripherals all drive; I2C master clock drives low to show who wins
        lvl <= 5'h10;
        poe <= 1'b1;
        pon <= 1'b1;
        plain_io_oe_i <= 5'h1f;
        for (int i = 0; i < 22; i++) begin
            p = ft[i][12:10];
            c = ft[i][9:2];
            bus(1'b1, 16'(P2PFS_PIN0_CFG_IDX + p), c, q);
            repeat (5) @(negedge clk_i);
            chk("pad oe", 32'(pad_oe_n_o[p]), 32'(ft[i][1]));
            if (!ft[i][1]) chk("pad out", 32'(pad_out_o[p]), 32'(ft[i][0]));
            chk("analog", 32'(analog_path_sel_o), c[7] ? 32'(1) << p : 32'h0);
            if (p == 3 && c == 8'h10) chk("rx", 32'(serial_two_receive_o), 32'h0);
            if (p == 4 && c == 8'h10) chk("t2", 32'(timer_two_input_o), 32'h1);
            bus(1'b0, P2PFS_CONFLICT_IDX, 8'h00, q);
            chk("conflict", q, (c == 8'h41) ? 32'h1 : 32'h0);
            bus(1'b1, 16'(P2PFS_PIN0_CFG_IDX + p), 8'h00, q);
        end
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
